// [logic/php_host_port.sv]
// Device-side host bus port: control/data register access, daisy chain.
// Assumes glue logic drives select, chip enable and strobes synchronously.
// Contract
// - control and data registers chosen by select
// - address write then data write programs register
// - address write then control read returns register
// - phase machine splits address from data writes
// - data register reached by single direct access
// - acknowledge read with chain enabled and a request pending sets in-service, drives vector
// - both strobes low resets the device
`timescale 1ns/1ps
module php_host_port
   import php_pkg::*;
#(
   parameter int unsigned NREGS = PHP_NREGS
)
(
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   // Host bus
   input  wire php_bus_s              i_bus,
   input  wire logic [PHP_DATA_W-1:0] i_data,
   output logic      [PHP_DATA_W-1:0] o_data,
   output logic                       o_data_oe,
   // Interrupt chain
   input  wire logic                  i_priority_enable_in,
   input  wire logic                  i_irq_event,
   input  wire logic [PHP_DATA_W-1:0] i_vector,
   output logic                       o_priority_enable_out,
   output logic                       o_irq_n,
   output logic                       o_in_service_flag,
   // Direct data path
   input  wire logic [PHP_DATA_W-1:0] i_rx_data,
   output logic      [PHP_DATA_W-1:0] o_tx_data,
   output logic                       o_tx_strobe,
   output logic                       o_rx_strobe,
   output logic      [PHP_DATA_W-1:0] o_reg0
);

   php_evt_s   evt;
   php_phase_e phase_r, phase_nxt;
   logic [PHP_IADDR_W-1:0] ptr_r, ptr_nxt;
   logic [PHP_DATA_W-1:0]  regs_r [NREGS];
   logic [PHP_DATA_W-1:0]  regs_nxt [NREGS];
   logic [PHP_DATA_W-1:0]  dout_r, dout_nxt, tx_r, tx_nxt;
   logic oe_r, oe_nxt, pend_r, pend_nxt, ius_r, ius_nxt;
   logic txs_r, txs_nxt, rxs_r, rxs_nxt;
   logic [1:0] sel;

   php_strobe_decode u_dec
   (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_bus   (i_bus),
      .o_evt   (evt)
   );

   assign sel = {i_bus.register_select_bit1, i_bus.register_select_bit0};

   always_comb
   begin
      phase_nxt = phase_r;
      ptr_nxt   = ptr_r;
      regs_nxt  = regs_r;
      dout_nxt  = dout_r;
      tx_nxt    = tx_r;
      txs_nxt   = 1'b0;
      rxs_nxt   = 1'b0;
      pend_nxt  = pend_r | i_irq_event;
      ius_nxt   = ius_r;
      // Drive data only while a read strobe is low
      oe_nxt    = oe_r && !i_bus.rd_n;
      if (evt.rst)
      begin
         phase_nxt = PHP_ST_ADDR;
         pend_nxt  = 1'b0;
         ius_nxt   = 1'b0;
         oe_nxt    = 1'b0;
         for (int i = 0; i < NREGS; i++)
            regs_nxt[i] = PHP_REG_RST;
      end
      else if (evt.ack_fall)
      begin
         if (i_priority_enable_in && pend_r)
         begin
            ius_nxt  = 1'b1;
            pend_nxt = i_irq_event;
            dout_nxt = i_vector;
            oe_nxt   = 1'b1;
         end
      end
      else if (evt.wr_fall)
      begin
         if (sel == PHP_SEL_CTRL)
         begin
            if (phase_r == PHP_ST_ADDR)
            begin
               ptr_nxt   = i_data[PHP_IADDR_W-1:0];
               phase_nxt = PHP_ST_DATA;
            end
            else
            begin
               regs_nxt[ptr_r] = i_data;
               phase_nxt       = PHP_ST_ADDR;
            end
         end
         else if (sel == PHP_SEL_DATA)
         begin
            tx_nxt  = i_data;
            txs_nxt = 1'b1;
         end
      end
      else if (evt.rd_fall)
      begin
         oe_nxt = 1'b1;
         if (sel == PHP_SEL_CTRL)
         begin
            dout_nxt  = regs_r[ptr_r];
            phase_nxt = PHP_ST_ADDR;
         end
         else
         begin
            dout_nxt = i_rx_data;
            rxs_nxt  = 1'b1;
         end
      end
      // Clearing the service flag uses register 0 bit 0 write of one
      if (!evt.rst && evt.wr_fall && sel == PHP_SEL_CTRL && phase_r == PHP_ST_DATA
          && ptr_r == '0 && i_data[0])
         ius_nxt = 1'b0;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         phase_r <= PHP_ST_ADDR;
         ptr_r   <= '0;
         for (int i = 0; i < NREGS; i++)
            regs_r[i] <= PHP_REG_RST;
         dout_r  <= PHP_VEC_RST;
         tx_r    <= '0;
         oe_r    <= 1'b0;
         pend_r  <= 1'b0;
         ius_r   <= 1'b0;
         txs_r   <= 1'b0;
         rxs_r   <= 1'b0;
      end
      else
      begin
         phase_r <= phase_nxt;
         ptr_r   <= ptr_nxt;
         regs_r  <= regs_nxt;
         dout_r  <= dout_nxt;
         tx_r    <= tx_nxt;
         oe_r    <= oe_nxt;
         pend_r  <= pend_nxt;
         ius_r   <= ius_nxt;
         txs_r   <= txs_nxt;
         rxs_r   <= rxs_nxt;
      end
   end

   // Chain output and request registered for flop-driven outputs
   logic ieo_r, irq_r;
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ieo_r <= 1'b0;
         irq_r <= 1'b1;
      end
      else
      begin
         ieo_r <= i_priority_enable_in && !ius_nxt && !pend_nxt;
         irq_r <= !(pend_nxt && !ius_nxt);
      end
   end

   assign o_data                = dout_r;
   assign o_data_oe             = oe_r;
   assign o_priority_enable_out = ieo_r;
   assign o_irq_n               = irq_r;
   assign o_in_service_flag     = ius_r;
   assign o_tx_data             = tx_r;
   assign o_tx_strobe           = txs_r;
   assign o_rx_strobe           = rxs_r;
   assign o_reg0                = regs_r[0];

   property p_addr_then_data;
      @(posedge i_clk) disable iff (!i_rst_n)
      (evt.wr_fall && !evt.rst && sel == PHP_SEL_CTRL && phase_r == PHP_ST_ADDR)
      |=> (phase_r == PHP_ST_DATA && ptr_r == $past(i_data[PHP_IADDR_W-1:0]));
   endproperty
   a_addr_then_data: assert property (p_addr_then_data)
      else $error("address write did not enter data phase");

   property p_rst_phase;
      @(posedge i_clk) disable iff (!i_rst_n)
      evt.rst |=> (phase_r == PHP_ST_ADDR && !ius_r);
   endproperty
   a_rst_phase: assert property (p_rst_phase)
      else $error("strobe reset did not clear state");

   property p_ctrl_read;
      @(posedge i_clk) disable iff (!i_rst_n)
      (evt.rd_fall && !evt.ack_fall && sel == PHP_SEL_CTRL)
      |=> (o_data == $past(regs_r[ptr_r]) && o_data_oe && phase_r == PHP_ST_ADDR);
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("control read returned wrong value");

   // Acknowledge taken, then vector driven, then chain closed below
   sequence s_ack_taken;
      evt.ack_fall && !evt.rst && i_priority_enable_in && pend_r;
   endsequence

   sequence s_vector_out;
      (ius_r && o_data_oe) ##1 !o_priority_enable_out;
   endsequence

   property p_ack;
      @(posedge i_clk) disable iff (!i_rst_n)
      s_ack_taken |=> s_vector_out;
   endproperty
   a_ack: assert property (p_ack)
      else $error("acknowledge did not set service flag");

   property p_data_write;
      @(posedge i_clk) disable iff (!i_rst_n)
      (evt.wr_fall && !evt.rst && sel == PHP_SEL_DATA)
      |=> (o_tx_strobe && o_tx_data == $past(i_data));
   endproperty
   a_data_write: assert property (p_data_write)
      else $error("direct data write not passed on");

   property p_data_read;
      @(posedge i_clk) disable iff (!i_rst_n)
      (evt.rd_fall && sel != PHP_SEL_CTRL)
      |=> (o_rx_strobe && o_data_oe && o_data == $past(i_rx_data));
   endproperty
   a_data_read: assert property (p_data_read)
      else $error("direct data read returned wrong value");
endmodule : php_host_port

// [inc/php_pkg.sv]
// Package for the peripheral host bus port: constants, states and carriers.
// Assumes a single clock domain; all bus pins are sampled synchronously.
package php_pkg;

   localparam int unsigned PHP_DATA_W   = 8;
   localparam int unsigned PHP_IADDR_W  = 4;
   localparam int unsigned PHP_NREGS    = 16;
   localparam logic [7:0]  PHP_REG_RST  = 8'h00;
   localparam logic [7:0]  PHP_VEC_RST  = 8'h00;

   // Register select codes on {bit1, bit0}
   localparam logic [1:0]  PHP_SEL_CTRL = 2'h0;
   localparam logic [1:0]  PHP_SEL_DATA = 2'h1;

   // Control register address/data phase
   typedef enum logic [0:0]
   {
      PHP_ST_ADDR = 1'b0,
      PHP_ST_DATA = 1'b1
   } php_phase_e;

   // Host bus pins; strobes and chip enable active low, select bits are plain codes
   typedef struct packed
   {
      logic chip_enable_n;
      logic rd_n;
      logic wr_n;
      logic irq_acknowledge_n;
      logic register_select_bit1;
      logic register_select_bit0;
   } php_bus_s;

   // Decoded events: falls last one cycle, rst lasts while both strobes are low
   typedef struct packed
   {
      logic rst;
      logic rd_fall;
      logic wr_fall;
      logic ack_fall;
   } php_evt_s;

endpackage : php_pkg

// [logic/php_strobe_decode.sv]
// Strobe edge decoder for the host bus port.
// Assumes bus strobes are synchronous to i_clk.
`timescale 1ns/1ps
module php_strobe_decode
   import php_pkg::*;
(
   // Clock and reset
   input  wire logic     i_clk,
   input  wire logic     i_rst_n,
   // Bus in
   input  wire php_bus_s i_bus,
   // Events out
   output php_evt_s      o_evt
);

   logic     rd_r;
   logic     wr_r;
   logic     rd_nxt;
   logic     wr_nxt;
   php_evt_s evt_nxt;
   php_evt_s evt_r;

   always_comb
   begin
      rd_nxt           = i_bus.rd_n;
      wr_nxt           = i_bus.wr_n;
      // Both strobes low together is a reset, never an access
      evt_nxt.rst      = !i_bus.rd_n && !i_bus.wr_n;
      evt_nxt.rd_fall  = rd_r && !i_bus.rd_n && i_bus.wr_n
                         && !i_bus.chip_enable_n && i_bus.irq_acknowledge_n;
      evt_nxt.wr_fall  = wr_r && !i_bus.wr_n && i_bus.rd_n
                         && !i_bus.chip_enable_n;
      evt_nxt.ack_fall = rd_r && !i_bus.rd_n && i_bus.wr_n
                         && !i_bus.irq_acknowledge_n;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rd_r  <= 1'b1;
         wr_r  <= 1'b1;
         evt_r <= '0;
      end
      else
      begin
         rd_r  <= rd_nxt;
         wr_r  <= wr_nxt;
         evt_r <= evt_nxt;
      end
   end

   assign o_evt = evt_r;

endmodule : php_strobe_decode

// [testbench/php_host_model.sv]
// Host glue model: chip enable, strobes, select and write data for the port.
// Assumes the bench supplies the clock; all changes land on the falling edge.
`timescale 1ns/1ps
module php_host_model
   import php_pkg::*;
(
   input  wire logic                  i_clk,
   input  wire logic [PHP_DATA_W-1:0] i_rdata,
   output php_bus_s                   o_bus,
   output logic      [PHP_DATA_W-1:0] o_wdata
);
   initial
   begin
      o_bus   = '1;
      o_wdata = 8'h00;
   end

   // Kind 0 write, 1 read, 2 acknowledge, 3 strobe reset
   task automatic cyc(input logic [1:0] kind, input logic [1:0] sel,
                      input logic [7:0] d, output logic [7:0] q);
      @(negedge i_clk);
      o_bus.chip_enable_n     = kind[1];
      o_bus.irq_acknowledge_n = (kind != 2'h2);
      {o_bus.register_select_bit1, o_bus.register_select_bit0} = sel;
      o_wdata                 = d;
      o_bus.wr_n              = (kind == 2'h1) || (kind == 2'h2);
      o_bus.rd_n              = (kind == 2'h0);
      repeat (4) @(negedge i_clk);
      q       = i_rdata;
      o_bus   = '1;
      // Released data lines do not keep the old value
      o_wdata = ~d;
      repeat (2) @(negedge i_clk);
   endtask : cyc
endmodule : php_host_model

// [testbench/php_host_port_tb.sv]
// Self-checking bench for the host bus port, random data with corner cases.
// Assumes the host model drives the bus; side inputs change on falling edges.
`timescale 1ns/1ps
module php_host_port_tb;
   import php_pkg::*;
   logic       clk, rst_n, pei, irq_ev, oe, peo, irq_n, in_service_flag, txs, rxs;
   logic [7:0] wdata, rdata, vec, rx, tx, reg0, q, a, d;
   logic [7:0] mem [16];
   php_bus_s   bus;
   int         n_fail, comparisons, seed, i;
   int         n_oe, n_txs, n_rxs, b_oe, b_txs, b_rxs;

   php_host_model host (.i_clk(clk), .i_rdata(rdata), .o_bus(bus), .o_wdata(wdata));
   php_host_port uut (.i_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .i_data(wdata),
      .o_data(rdata), .o_data_oe(oe), .i_priority_enable_in(pei), .i_irq_event(irq_ev),
      .i_vector(vec), .o_priority_enable_out(peo), .o_irq_n(irq_n),
      .o_in_service_flag(in_service_flag), .i_rx_data(rx), .o_tx_data(tx), .o_tx_strobe(txs),
      .o_rx_strobe(rxs), .o_reg0(reg0));

   function automatic logic [7:0] exp_data(input logic [1:0] sel, input logic [7:0] r, m);
      return (sel == PHP_SEL_DATA) ? r : m;
   endfunction : exp_data

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_flag(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : chk_flag

   task automatic chk_cnt(input int got, input int exp);
      comparisons++;
      if (got != exp)
      begin
         n_fail++;
         $display("unexpected at %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask : chk_cnt

   task automatic mark;
      b_oe  = n_oe;
      b_txs = n_txs;
      b_rxs = n_rxs;
   endtask : mark

   // Counts clock edges with drive enable high and strobe pulses
   always @(posedge clk)
   begin
      n_oe  <= n_oe + int'(oe === 1'b1);
      n_txs <= n_txs + int'(txs === 1'b1);
      n_rxs <= n_rxs + int'(rxs === 1'b1);
   end

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial
   begin
      #16000;
      n_fail++;
      print_verdict();
   end

   initial
   begin
      seed = 7419;
      n_fail = 0;
      comparisons = 0;
      rst_n = 1'b0;
      pei = 1'b1;
      irq_ev = 1'b0;
      vec = 8'h00;
      rx = 8'h00;
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      chk_flag(irq_n, 1'b1);
      chk_flag(peo, 1'b1);
      chk_flag(oe, 1'b0);
      chk(reg0, PHP_REG_RST);
      // Address then data, then address then read back
      for (i = 0; i < 8; i++)
      begin
         a = (i == 0) ? 8'h00 : (i == 1) ? 8'h0F : 8'h0F & $random(seed);
         d = (i == 0) ? 8'hFE : $random(seed);
         mem[a[3:0]] = d;
         mark();
         host.cyc(2'h0, PHP_SEL_CTRL, a, q);
         host.cyc(2'h0, PHP_SEL_CTRL, d, q);
         if (a == 8'h00)
            chk(reg0, d);
         host.cyc(2'h0, PHP_SEL_CTRL, a, q);
         chk_flag(n_oe != b_oe, 1'b0);
         host.cyc(2'h1, PHP_SEL_CTRL, 8'h00, q);
         chk(q, exp_data(PHP_SEL_CTRL, rx, mem[a[3:0]]));
         chk_flag(n_oe != b_oe, 1'b1);
         chk_flag(oe, 1'b0);
         chk_cnt(n_txs + n_rxs - b_txs - b_rxs, 0);
      end
      // Direct data register access
      for (i = 0; i < 4; i++)
      begin
         d = $random(seed);
         rx = $random(seed);
         mark();
         host.cyc(2'h0, PHP_SEL_DATA, d, q);
         chk(tx, d);
         chk_cnt(n_txs - b_txs, 1);
         host.cyc(2'h1, PHP_SEL_DATA, 8'h00, q);
         chk(q, exp_data(PHP_SEL_DATA, rx, 8'h00));
         chk_cnt(n_rxs - b_rxs, 1);
      end
      // Strobe reset in the data phase, register 0 loaded beforehand
      host.cyc(2'h0, PHP_SEL_CTRL, 8'h00, q);
      host.cyc(2'h0, PHP_SEL_CTRL, 8'h5A, q);
      chk(reg0, 8'h5A);
      host.cyc(2'h0, PHP_SEL_CTRL, 8'h03, q);
      host.cyc(2'h3, PHP_SEL_CTRL, 8'h00, q);
      chk(reg0, PHP_REG_RST);
      host.cyc(2'h0, PHP_SEL_CTRL, 8'h00, q);
      host.cyc(2'h0, PHP_SEL_CTRL, 8'h3C, q);
      chk(reg0, 8'h3C);
      // Interrupt held off by the chain, then acknowledged, then cleared
      pei = 1'b0;
      vec = $random(seed);
      irq_ev = 1'b1;
      @(negedge clk);
      irq_ev = 1'b0;
      repeat (3) @(negedge clk);
      chk_flag(irq_n, 1'b0);
      chk_flag(peo, 1'b0);
      mark();
      host.cyc(2'h2, PHP_SEL_CTRL, 8'h00, q);
      chk_flag(in_service_flag, 1'b0);
      chk_flag(n_oe != b_oe, 1'b0);
      pei = 1'b1;
      mark();
      host.cyc(2'h2, PHP_SEL_CTRL, 8'h00, q);
      chk(q, vec);
      chk_flag(in_service_flag, 1'b1);
      chk_flag(n_oe != b_oe, 1'b1);
      chk_flag(irq_n, 1'b1);
      chk_flag(peo, 1'b0);
      host.cyc(2'h0, PHP_SEL_CTRL, 8'h00, q);
      host.cyc(2'h0, PHP_SEL_CTRL, 8'h01, q);
      chk_flag(in_service_flag, 1'b0);
      chk_flag(peo, 1'b1);
      print_verdict();
   end
endmodule : php_host_port_tb
